// ---- hdl/fbn_host.sv ----
// Driver-side feature negotiation controller with Wishbone register port
// Operation
// [R01] Indirect descriptors usable once bit 28 negotiated
// [R02] Event index fields used only when negotiated
// [R03] Device always offers compliance bit 32
// [R04] Driver accepts compliance bit; refuses without it
// [R05] Bit 33 marks platform-limited device memory access
// [R06] Bit 33 clear: untranslated physical addresses
// [R07] Not offered: physical only; accepted: program translation
// [R08] Device offers bit 33 when platform translates
// [R09] Bit 34 packed rings; driver accepts when offered
// [R10] Bit 35 announces in-order buffer completion
// [R11] Negotiated in-order: device returns buffers in order
// [R12] Bit 36 selects platform memory ordering
// [R13] Ordering bit: accept it, use hardware barriers
// [R14] Ordering refused: device may stop or emulate
// [R15] PCI cards offer bits 33 and 36
// [R16] Device offers bit 37 only with capability
// [R17] Never negotiate bit 37 without PCI capability
// [R18] Virtual functions only after bit 37 negotiated
// [R19] Once negotiated, virtual functions survive resets; i_rst clears the bit 37 memory here
// [R20] Bit 38 adds data to notifications
// [R21] Negotiated means offered and accepted
`timescale 1ns/10ps
module fbn_host
	import fbn_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Wishbone classic slave
	input  wire logic              i_wb_cyc,
	input  wire logic              i_wb_stb,
	input  wire logic              i_wb_we,
	input  wire logic [ADR_W-1:0]  i_wb_adr,
	input  wire logic [31:0]       i_wb_dat,
	input  wire logic [3:0]        i_wb_sel,
	output logic      [31:0]       o_wb_dat,
	output logic                   o_wb_ack,
	// Device feature pins
	input  wire logic [FEAT_W-1:0] i_dev_offer,
	input  wire logic              i_dev_feat_ok,
	output logic      [FEAT_W-1:0] o_accept,
	output logic                   o_accept_valid,
	// Negotiated modes
	output logic                   o_use_indirect,
	output logic                   o_use_event_idx,
	output logic                   o_use_packed,
	output logic                   o_in_order,
	output logic                   o_hw_barriers,
	output logic                   o_notify_data,
	output logic                   o_phys_addr_only,
	output logic                   o_vf_enable
);

	// Synchroniser stages for device pins
	logic [FEAT_W-1:0] off_m;
	logic [FEAT_W-1:0] off_s;
	logic              ok_m;
	logic              ok_s;

	// Controller state
	fbn_state_t        state;
	fbn_state_t        next_state;
	logic [FEAT_W-1:0] off_lat;
	logic [FEAT_W-1:0] next_off_lat;
	logic [FEAT_W-1:0] acc;
	logic [FEAT_W-1:0] next_acc;
	logic [FEAT_W-1:0] neg;
	logic [FEAT_W-1:0] next_neg;
	logic [FEAT_W-1:0] want;
	logic [FEAT_W-1:0] next_want;
	logic [CTRL_W-1:0] ctrl;
	logic [CTRL_W-1:0] next_ctrl;
	logic              ever;
	logic              next_ever;
	logic              vf;
	logic              next_vf;
	logic              phys;
	logic              next_phys;
	logic              ack;
	logic              next_ack;
	logic [31:0]       rdat;
	logic [31:0]       next_rdat;
	logic [31:0]       rd_mux;
	logic [31:0]       stat;
	logic              req;
	logic              wr;
	logic              start;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	// Byte-lane merge for partial writes
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// Accept vector built from the offer and software wishes
	function automatic logic [FEAT_W-1:0] calc_accept(input logic [FEAT_W-1:0] off,
		input logic [FEAT_W-1:0] w, input logic pci, input logic xlat);
		logic [FEAT_W-1:0] a;
		a = off & w;
		// [R04] compliance bit forced
		a[B_VER1] = off[B_VER1];
		// [R09] packed layout accepted
		a[B_PACKED] = off[B_PACKED];
		// [R13] platform ordering accepted
		a[B_ORDPLAT] = off[B_ORDPLAT];
		// [R07] translation only when programmed
		a[B_PLAT] = off[B_PLAT] & xlat;
		// [R17] no virtualization without capability
		a[B_SRIOV] = off[B_SRIOV] & w[B_SRIOV] & pci;
		return a;
	endfunction : calc_accept

	// Two-flop synchronisers; pins come from another domain
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			off_m <= '0;
			off_s <= '0;
			ok_m  <= 1'b0;
			ok_s  <= 1'b0;
		end else begin
			off_m <= i_dev_offer;
			off_s <= off_m;
			ok_m  <= i_dev_feat_ok;
			ok_s  <= ok_m;
		end
	end

	// Bus request decode
	assign req = i_wb_cyc & i_wb_stb;
	assign wr  = req & ack & i_wb_we;
	assign start = wr && (i_wb_adr == A_CTRL) && i_wb_sel[0] && i_wb_dat[C_START];

	// Status word
	always_comb begin
		stat          = 32'h0;
		stat[S_BUSY]  = (state == ST_WAIT);
		stat[S_DONE]  = (state == ST_DONE);
		stat[S_FAIL]  = (state == ST_FAIL);
		stat[S_VF]    = vf;
		stat[S_SRIOV] = ever;
	end

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		unique case (i_wb_adr)
			A_CTRL:    rd_mux = {28'h0, ctrl[CTRL_W-1:1], 1'b0};
			A_STAT:    rd_mux = stat;
			A_WANT_LO: rd_mux = want[31:0];
			A_WANT_HI: rd_mux = want[63:32];
			A_OFF_LO:  rd_mux = off_s[31:0];
			A_OFF_HI:  rd_mux = off_s[63:32];
			A_NEG_LO:  rd_mux = neg[31:0];
			A_NEG_HI:  rd_mux = neg[63:32];
			default:   rd_mux = 32'h0;
		endcase
	end

	// Next values: bus writes and negotiation sequence
	always_comb begin
		next_state   = state;
		next_off_lat = off_lat;
		next_acc     = acc;
		next_neg     = neg;
		next_want    = want;
		next_ctrl    = ctrl;
		next_ever    = ever;
		next_phys    = phys;
		next_ack     = 1'b0;
		next_rdat    = rdat;
		// Ack one cycle after the request, dropped the cycle after
		if (req && !ack) begin
			next_ack  = 1'b1;
			next_rdat = rd_mux;
		end
		// Writes land on the edge where the master sees ack
		if (wr) begin
			unique case (i_wb_adr)
				A_CTRL:    next_ctrl = CTRL_W'(wmerge({28'h0, ctrl}, i_wb_dat, i_wb_sel));
				A_WANT_LO: next_want[31:0] = wmerge(want[31:0], i_wb_dat, i_wb_sel);
				A_WANT_HI: next_want[63:32] = wmerge(want[63:32], i_wb_dat, i_wb_sel);
				default:   next_ctrl = ctrl;
			endcase
		end
		next_ctrl[C_START] = 1'b0;
		unique case (state)
			ST_IDLE, ST_DONE, ST_FAIL: begin
				// Start is ignored while a handshake is in flight
				if (start) begin
					next_off_lat = off_s;
					next_neg     = '0;
					// [R04] refuse device lacking compliance
					if (!off_s[B_VER1]) begin
						next_acc   = '0;
						next_state = ST_FAIL;
					end else begin
						next_acc   = calc_accept(off_s, next_want, next_ctrl[C_PCI], next_ctrl[C_XLAT]);
						next_state = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				// Device confirms the accepted set
				if (ok_s) begin
					// [R21] negotiated is offered and accepted
					next_neg   = off_lat & acc;
					// [R07] not negotiated means physical addresses
					next_phys  = ~(off_lat[B_PLAT] & acc[B_PLAT]);
					// [R19] capability kept across later negotiations; cleared by i_rst
					next_ever  = ever | (off_lat[B_SRIOV] & acc[B_SRIOV]);
					next_state = ST_DONE;
				end
			end
			// Illegal one-hot code: back to idle rather than lock up
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// [R18] virtual functions gated by completed negotiation
	always_comb begin
		next_vf = ctrl[C_VF] & ever;
	end

	// State registers
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state   <= ST_IDLE;
			off_lat <= '0;
			acc     <= '0;
			neg     <= '0;
			want    <= WANT_RST;
			ctrl    <= CTRL_RST;
			ever    <= 1'b0;
			vf      <= 1'b0;
			phys    <= 1'b1;
			ack     <= 1'b0;
			rdat    <= 32'h0;
		end else begin
			state   <= next_state;
			off_lat <= next_off_lat;
			acc     <= next_acc;
			neg     <= next_neg;
			want    <= next_want;
			ctrl    <= next_ctrl;
			ever    <= next_ever;
			vf      <= next_vf;
			phys    <= next_phys;
			ack     <= next_ack;
			rdat    <= next_rdat;
		end
	end

	// Outputs; accept vector held stable through the handshake
	assign o_wb_ack       = ack;
	assign o_wb_dat       = rdat;
	assign o_accept       = acc;
	assign o_accept_valid = (state == ST_WAIT);
	// [R01] indirect tables after negotiation
	assign o_use_indirect   = neg[B_INDIRECT];
	// [R02] event index only when negotiated
	assign o_use_event_idx  = neg[B_EVIDX];
	// [R09] packed ring layout
	assign o_use_packed     = neg[B_PACKED];
	assign o_in_order       = neg[B_INORD];
	// [R12] hardware ordering follows the bit
	assign o_hw_barriers    = neg[B_ORDPLAT];
	// [R20] notifications carry extra data
	assign o_notify_data    = neg[B_NDATA];
	assign o_phys_addr_only = phys;
	assign o_vf_enable      = vf;

	// Handshake sequences
	sequence s_confirm;
		(state == ST_WAIT) && ok_s;
	endsequence
	sequence s_bad_start;
		start && (state != ST_WAIT) && !off_s[B_VER1];
	endsequence
	sequence s_good_start;
		start && (state != ST_WAIT) && off_s[B_VER1];
	endsequence

	a_ver_forced: assert property ((state == ST_WAIT) && off_lat[B_VER1] |-> o_accept[B_VER1]) // [R04]
		else $error("compliance bit not accepted");
	a_ver_refuse: assert property (s_bad_start |=> (state == ST_FAIL) && !o_accept_valid) // [R04]
		else $error("missing compliance bit not refused");
	a_packed_acc: assert property (o_accept_valid && off_lat[B_PACKED] |-> o_accept[B_PACKED]) // [R09]
		else $error("packed layout not accepted");
	a_order_acc: assert property (o_accept_valid && off_lat[B_ORDPLAT] |-> o_accept[B_ORDPLAT]) // [R13]
		else $error("ordering bit not accepted");
	a_sriov_pci: assert property (o_accept_valid && o_accept[B_SRIOV] |-> ctrl[C_PCI]) // [R17]
		else $error("virtualization accepted without capability");
	a_vf_gate: assert property ($rose(o_vf_enable) |-> $past(ever) && $past(ctrl[C_VF])) // [R18]
		else $error("virtual functions enabled too early");
	a_neg_and: assert property (s_confirm |=> (neg == (off_lat & o_accept)) && (state == ST_DONE)) // [R21]
		else $error("negotiated set wrong");
	a_phys_only: assert property (s_confirm ##1 !neg[B_PLAT] |-> o_phys_addr_only) // [R07]
		else $error("translation assumed without negotiation");
	a_ever_keep: assert property (ever |=> ever) // [R19]
		else $error("virtualization memory lost");
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held two cycles");

	// Bus answer comes exactly one cycle after the request is taken
	a_ack_late: assert property (req && !o_wb_ack |=> o_wb_ack)
		else $error("ack missing after request");
	// A start during the handshake must not disturb the accepted set
	a_busy_hold: assert property ((state == ST_WAIT) && !ok_s |=> (state == ST_WAIT) && $stable(o_accept))
		else $error("handshake disturbed while busy");
	a_valid_drop: assert property (s_confirm |=> !o_accept_valid)
		else $error("accept valid held after confirm");
	a_accept_sub: assert property (s_good_start |=> o_accept_valid && ((o_accept & ~off_lat) == '0)) // [R21]
		else $error("accepted bit never offered");
	a_fail_quiet: assert property ((state == ST_FAIL) |-> !o_accept_valid && (o_accept == '0)) // [R04]
		else $error("refused device still sees an accept set");
	// Mode outputs follow offered and accepted bits after confirm
	a_evidx_mode: assert property (s_confirm |=> o_use_event_idx == (off_lat[B_EVIDX] & o_accept[B_EVIDX])) // [R02]
		else $error("event index mode wrong");
	a_packed_mode: assert property (s_confirm |=> o_use_packed == (off_lat[B_PACKED] & o_accept[B_PACKED])) // [R09]
		else $error("packed ring mode wrong");
	a_order_mode: assert property (s_confirm |=> o_hw_barriers == (off_lat[B_ORDPLAT] & o_accept[B_ORDPLAT])) // [R12]
		else $error("barrier mode wrong");
	a_ndata_mode: assert property (s_confirm |=> o_notify_data == (off_lat[B_NDATA] & o_accept[B_NDATA])) // [R20]
		else $error("notification data mode wrong");
	// Virtual functions stay off until bit 37 was negotiated once
	a_vf_no_ever: assert property (!ever |-> !o_vf_enable) // [R18]
		else $error("virtual functions on without negotiation");

endmodule : fbn_host

// ---- hdl/fbn_pkg.sv ----
// Constants and types for the feature negotiation controller
package fbn_pkg;
	// Feature vector width and bit positions
	localparam int FEAT_W     = 64;
	localparam int B_INDIRECT = 28;
	localparam int B_EVIDX    = 29;
	localparam int B_VER1     = 32;
	localparam int B_PLAT     = 33;
	localparam int B_PACKED   = 34;
	localparam int B_INORD    = 35;
	localparam int B_ORDPLAT  = 36;
	localparam int B_SRIOV    = 37;
	localparam int B_NDATA    = 38;
	// Register byte offsets
	localparam int        ADR_W     = 6;
	localparam logic [5:0] A_CTRL    = 6'h00;
	localparam logic [5:0] A_STAT    = 6'h04;
	localparam logic [5:0] A_WANT_LO = 6'h08;
	localparam logic [5:0] A_WANT_HI = 6'h0C;
	localparam logic [5:0] A_OFF_LO  = 6'h10;
	localparam logic [5:0] A_OFF_HI  = 6'h14;
	localparam logic [5:0] A_NEG_LO  = 6'h18;
	localparam logic [5:0] A_NEG_HI  = 6'h1C;
	// Control register fields
	localparam int C_START = 0;
	localparam int C_PCI   = 1;
	localparam int C_XLAT  = 2;
	localparam int C_VF    = 3;
	localparam int CTRL_W  = 4;
	// Status register fields
	localparam int S_BUSY  = 0;
	localparam int S_DONE  = 1;
	localparam int S_FAIL  = 2;
	localparam int S_VF    = 3;
	localparam int S_SRIOV = 4;
	// Reset values
	localparam logic [63:0] WANT_RST = 64'hFFFFFFFFFFFFFFFF;
	localparam logic [3:0]  CTRL_RST = 4'h0;
	// Negotiation states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_DONE = 4'h4,
		ST_FAIL = 4'h8
	} fbn_state_t;
endpackage : fbn_pkg

// ---- tb/fbn_dev_model.sv ----
// Device-side model that offers features and confirms the accepted set
`timescale 1ns/10ps
module fbn_dev_model
	import fbn_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Settings from the bench
	input  wire logic [FEAT_W-1:0] i_cfg_offer,
	input  wire logic [7:0]        i_cfg_delay,
	// Pins facing the controller
	input  wire logic [FEAT_W-1:0] i_accept,
	input  wire logic              i_accept_valid,
	output logic      [FEAT_W-1:0] o_offer,
	output logic                   o_feat_ok
);
	logic [7:0] wait_cnt;

	assign o_offer = i_cfg_offer;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wait_cnt  <= 8'h00;
			o_feat_ok <= 1'b0;
		end else if (!i_accept_valid) begin
			wait_cnt  <= 8'h00;
			o_feat_ok <= 1'b0; // Dropped before the next start
		end else if (wait_cnt < i_cfg_delay) begin
			wait_cnt <= wait_cnt + 8'h01; // Slow answer on request
		end else begin
			o_feat_ok <= ((i_accept & ~o_offer) == '0) && i_accept[B_VER1]
				&& !(o_offer[B_ORDPLAT] && !i_accept[B_ORDPLAT]);
		end
	end
endmodule : fbn_dev_model

// ---- tb/testbench.sv ----
// Self-checking bench for the feature negotiation controller
`timescale 1ns/10ps
module testbench
	import fbn_pkg::*;
;
	typedef struct packed {
		logic [63:0] offer;
		logic [63:0] want;
		logic [3:0]  ctrl;
		logic [63:0] accept;
	} fbn_row_t;
	logic        i_clock = 1'b0;
	logic        i_rst   = 1'b1;
	logic        req     = 1'b0;
	logic        we      = 1'b0;
	logic [5:0]  adr     = 6'h00;
	logic [31:0] dat     = 32'h0;
	logic [3:0]  sel     = 4'hF;
	logic [31:0] wb_dat;
	logic        ack;
	logic [63:0] offer;
	logic        feat_ok;
	logic [63:0] o_accept;
	logic        o_accept_valid;
	logic        o_use_indirect, o_use_event_idx, o_use_packed, o_in_order;
	logic        o_hw_barriers, o_notify_data, o_phys_addr_only, o_vf_enable;
	logic [63:0] cfg_offer = 64'h0;
	logic [7:0]  cfg_delay = 8'h00;
	logic [31:0] q;
	logic [63:0] a;
	int          n_errors = 0;
	int          n_checks = 0;
	// Offer, wanted set, control bits, expected accepted set
	fbn_row_t    rows [4] = '{
		'{64'h0000007F_30000000, 64'hFFFFFFFF_FFFFFFFF, 4'h6, 64'h0000007F_30000000},
		'{64'h0000007F_30000000, 64'h0, 4'h0, 64'h00000015_00000000},
		'{64'h0000007F_30000000, 64'hFFFFFFFF_FFFFFFFF, 4'h0, 64'h0000005D_30000000},
		'{64'h00000001_00000000, 64'hFFFFFFFF_FFFFFFFF, 4'h6, 64'h00000001_00000000}};

	// 200 MHz clock
	always #2.5 i_clock = ~i_clock;

	fbn_host dut (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(wb_dat), .o_wb_ack(ack),
		.i_dev_offer(offer), .i_dev_feat_ok(feat_ok), .o_accept(o_accept),
		.o_accept_valid(o_accept_valid), .o_use_indirect(o_use_indirect),
		.o_use_event_idx(o_use_event_idx), .o_use_packed(o_use_packed), .o_in_order(o_in_order),
		.o_hw_barriers(o_hw_barriers), .o_notify_data(o_notify_data),
		.o_phys_addr_only(o_phys_addr_only), .o_vf_enable(o_vf_enable));

	fbn_dev_model dev (.i_clock(i_clock), .i_rst(i_rst), .i_cfg_offer(cfg_offer),
		.i_cfg_delay(cfg_delay), .i_accept(o_accept), .i_accept_valid(o_accept_valid),
		.o_offer(offer), .o_feat_ok(feat_ok));

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Classic cycle held until ack, then one idle cycle
	task automatic wb(input logic w, input logic [5:0] ad, input logic [31:0] d, output logic [31:0] r,
		input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		req <= 1'b1;
		we  <= w;
		adr <= ad;
		dat <= d;
		sel <= s;
		// Only the watchdog ends a wait for ack
		do begin
			@(posedge i_clock);
			n++;
		end while (ack !== 1'b1);
		r = wb_dat;
		req <= 1'b0;
		@(posedge i_clock);
		// Ack one cycle after the request is taken
		chk("ack_lat", 64'h2, 64'(n));
	endtask : wb

	// Program the wanted set, start, poll status until settled
	task automatic run(input fbn_row_t rw, input logic [7:0] dly, output logic [31:0] st);
		int n;
		n = 0;
		cfg_offer <= rw.offer;
		cfg_delay <= dly;
		repeat (4) @(posedge i_clock); // Let the pin synchronisers settle
		wb(1'b1, A_WANT_LO, rw.want[31:0], st);
		wb(1'b1, A_WANT_HI, rw.want[63:32], st);
		wb(1'b1, A_CTRL, {28'h0, rw.ctrl} | 32'h1, st);
		chk("acc_valid", 64'(rw.offer[B_VER1]), 64'(o_accept_valid));
		do begin
			wb(1'b0, A_STAT, 32'h0, st);
			n++;
		end while (st[S_DONE] !== 1'b1 && st[S_FAIL] !== 1'b1 && n < 100);
	endtask : run

	task automatic results();
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// Watchdog, far beyond the expected run
	initial begin
		#100000;
		n_errors++;
		results();
	end

	initial begin
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		chk("accept", 64'h0, o_accept);
		chk("phys", 64'h1, 64'(o_phys_addr_only));
		wb(1'b0, A_WANT_HI, 32'h0, q);
		chk("want_hi", 64'hFFFFFFFF, 64'(q));
		// Byte lane 1 only: the other lanes keep their value
		wb(1'b1, A_WANT_HI, 32'h0, q, 4'h2);
		wb(1'b0, A_WANT_HI, 32'h0, q);
		chk("want_sel", 64'hFFFF00FF, 64'(q));
		wb(1'b0, 6'h20, 32'h0, q);
		chk("unmapped", 64'h0, 64'(q));
		wb(1'b1, A_CTRL, 32'h8, q);
		repeat (2) @(posedge i_clock);
		chk("vf_early", 64'h0, 64'(o_vf_enable));
		// Table of negotiations, prompt to slow device
		foreach (rows[i]) begin
			run(rows[i], 8'(i * 6 + 6), q);
			a = rows[i].accept;
			chk("done", 64'h1, 64'(q[S_DONE]));
			chk("accept", a, o_accept);
			chk("modes", 64'({a[28], a[29], a[34], a[35], a[36], a[38], ~a[33]}), 64'({o_use_indirect,
				o_use_event_idx, o_use_packed, o_in_order, o_hw_barriers, o_notify_data,
				o_phys_addr_only}));
			wb(1'b0, A_NEG_HI, 32'h0, q);
			chk("neg_hi", 64'(a[63:32]), 64'(q));
		end
		// Allowed after one earlier negotiation of bit 37
		wb(1'b1, A_CTRL, 32'h8, q);
		repeat (2) @(posedge i_clock);
		chk("vf_later", 64'h1, 64'(o_vf_enable));
		// Offer lacking the compliance bit is refused
		run('{64'h00000000_30000000, 64'hFFFFFFFF_FFFFFFFF, 4'h0, 64'h0}, 8'h06, q);
		chk("fail", 64'h1, 64'(q[S_FAIL]));
		chk("accept_f", 64'h0, o_accept);
		// Second reset mid-run
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		chk("vf_rst", 64'h0, 64'(o_vf_enable));
		chk("phys_rst", 64'h1, 64'(o_phys_addr_only));
		results();
	end
endmodule : testbench
